// File: rtl/psch_consts.svh
// Constants of the port injection pulse scheduler
`ifndef PSCH_CONSTS_SVH
`define PSCH_CONSTS_SVH
`define PSCH_CLK_MHZ 100
`define PSCH_TICK_US 10
`define PSCH_TICK_CYC (`PSCH_TICK_US * `PSCH_CLK_MHZ)
`define PSCH_CNT_W 10
`define PSCH_CH 4
`define PSCH_ANG_W 10
`define PSCH_CYCLE_DEG 10'h2d0
`define PSCH_SPD_FRAC 8
`define PSCH_MODE_BIT 0
`define PSCH_PEN_BIT 1
`define PSCH_SKIP_LSB 4
`define PSCH_SKIP_RST 8'h01
`define PSCH_G_CTRL 4'h0
`define PSCH_G_DELAY 4'h1
`define PSCH_G_DUR 4'h2
`define PSCH_G_SOI 4'h3
`define PSCH_G_TDC 4'h4
`define PSCH_G_CAD 4'h5
`define PSCH_G_STAT 4'h6
`define PSCH_R_CTRL 2'h0
`define PSCH_R_TRIG 2'h1
`define PSCH_R_LEN 2'h2
`define PSCH_R_ACT 2'h3
`define PSCH_R_CAM_PHASE_INPUT_ONE 2'h0
`define PSCH_R_CAM_PHASE_INPUT_TWO 2'h1
`define PSCH_R_STAT 2'h2
`define PSCH_OKAY 2'h0
`define PSCH_SLVERR 2'h2
`endif

// File: rtl/psch_pkg.sv
// Types of the port injection pulse scheduler
package psch_pkg;
  typedef enum logic [1:0] {TMR_IDLE, TMR_DELAY, TMR_PULSE} psch_tmr_state_t;
  typedef struct packed {
    logic [9:0] cnt;
    logic tick;
  } psch_div_t;
  typedef struct packed {
    psch_tmr_state_t st;
    logic [15:0] cnt;
    logic [15:0] dur;
    logic en;
    logic cmd;
  } psch_tmr_t;
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic mode;
    logic pen;
    logic [3:0] skip_en;
    logic [7:0] skip_len;
    logic [7:0] skip_act;
    logic [3:0][15:0] delay;
    logic [3:0][15:0] dur;
    logic [3:0][9:0] injection_start_point;
    logic [3:0][9:0] tdc;
    logic [1:0][9:0] cam_cap;
    logic [1:0] cam_s1;
    logic [1:0] cam_s2;
    logic [1:0] cam_prev;
    logic [9:0] prev_ang;
    logic [3:0][7:0] skip_cnt;
    logic [3:0] skip_en_prev;
    logic [3:0] pend;
    logic [3:0] cmd;
  } psch_top_t;
endpackage : psch_pkg

// File: rtl/psch_tick_div.sv
// Time base divider giving one tick per time unit
`timescale 1ns/1ps
`default_nettype none
`include "psch_consts.svh"
module psch_tick_div
  import psch_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  output logic tick
);
  psch_div_t q, d;

  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == 10'(`PSCH_TICK_CYC - 1))
    begin
      d.cnt = '0;
      d.tick = 1'b1;
    end
    else
      d.cnt = q.cnt + 10'h001;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= d;
  end

  assign tick = q.tick;

  tick_gap_a:
  assert property (@(posedge clk) disable iff (!arst_n)
    tick |=> !tick [*8])
  else $error("Tick came too soon");
endmodule : psch_tick_div
`default_nettype wire

// File: rtl/psch_timer.sv
// One channel pulse timer: delay, then duration, with masking
`timescale 1ns/1ps
`default_nettype none
`include "psch_consts.svh"
module psch_timer
  import psch_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic start,
  input wire logic [15:0] delay,
  input wire logic [15:0] dur,
  input wire logic fire_en,
  output logic cmd,
  output logic busy
);
  psch_tmr_t q, d;

  always_comb
  begin
    d = q;
    unique case (q.st)
      TMR_IDLE:
        if (start)
        begin
          d.dur = dur;
          d.en = fire_en;
          if (delay != 16'h0000)
          begin
            d.st = TMR_DELAY;
            d.cnt = delay;
          end
          else if (dur != 16'h0000)
          begin
            d.st = TMR_PULSE;
            d.cnt = dur;
          end
        end
      TMR_DELAY:
        if (tick)
        begin
          d.cnt = q.cnt - 16'h0001;
          if (q.cnt == 16'h0001)
          begin
            d.st = (q.dur != 16'h0000) ? TMR_PULSE : TMR_IDLE;
            d.cnt = q.dur;
          end
        end
      TMR_PULSE:
        if (tick)
        begin
          d.cnt = q.cnt - 16'h0001;
          if (q.cnt == 16'h0001)
            d.st = TMR_IDLE;
        end
    endcase
    d.cmd = (d.st == TMR_PULSE) && d.en;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      q <= '0;
    else
      q <= d;
  end

  assign cmd = q.cmd;
  assign busy = (q.st != TMR_IDLE);

  mask_hold_a:
  assert property (@(posedge clk) disable iff (!arst_n)
    (busy && !q.en) |-> !cmd)
  else $error("Masked pulse drove the command");

  pulse_start_a:
  assert property (@(posedge clk) disable iff (!arst_n)
    (!busy && start && fire_en && delay == 16'h0000 && dur != 16'h0000) |=> cmd)
  else $error("Enabled pulse did not start");
endmodule : psch_timer
`default_nettype wire

// File: rtl/psch_top.sv
// Port injection pulse scheduler with AXI4-Lite registers
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "psch_consts.svh"
module psch_top
  import psch_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic ARST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [9:0] CRANK_ANGLE,
  input wire logic CRANK_VALID,
  input wire logic [15:0] ENGINE_SPEED,
  input wire logic CAM_PHASE_INPUT_ONE,
  input wire logic CAM_PHASE_INPUT_TWO,
  output logic [3:0] INJ_CMD
);
  psch_top_t q, d;
  logic tick;
  logic [3:0] start_p;
  logic [3:0] fire_en;
  logic [3:0] busy;
  logic [3:0] tcmd;
  logic [3:0] crank_fire;
  logic [3:0] launch;
  logic new_cycle;
  logic [1:0] cam_rise;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        r[b*8 +: 8] = nw[b*8 +: 8];
    return r;
  endfunction : merge

  // Target angle in the cycle: reference minus advance, wrapped
  function automatic logic [9:0] fire_ang(input logic [9:0] tdc, input logic [9:0] injection_start_point);
    if (injection_start_point > tdc)
      return 10'(tdc + `PSCH_CYCLE_DEG - injection_start_point);
    else
      return 10'(tdc - injection_start_point);
  endfunction : fire_ang

  // Angle steps may skip values at speed, so test a crossing, not equality
  function automatic logic crossed(input logic [9:0] prev, input logic [9:0] cur,
                                   input logic [9:0] tgt);
    if (cur >= prev)
      return (tgt > prev) && (tgt <= cur);
    else
      return (tgt > prev) || (tgt <= cur);
  endfunction : crossed

  function automatic logic [15:0] cad(input logic [15:0] dur, input logic [15:0] spd);
    logic [31:0] p;
    p = dur * spd;
    return p[`PSCH_SPD_FRAC +: 16];
  endfunction : cad

  psch_tick_div u_div (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .tick(tick)
  );

  for (genvar c = 0; c < `PSCH_CH; c++)
  begin : g_ch
    psch_timer u_tmr (
      .clk(CORE_CLK),
      .arst_n(ARST_N),
      .tick(tick),
      .start(start_p[c]),
      .delay(q.mode ? 16'h0000 : q.delay[c]),
      .dur(q.dur[c]),
      .fire_en(fire_en[c]),
      .cmd(tcmd[c]),
      .busy(busy[c])
    );
  end

  always_comb
  begin
    logic [3:0] trig;
    logic [3:0] g;
    logic [1:0] r;
    logic [31:0] m;
    trig = '0;
    g = '0;
    r = '0;
    m = '0;
    d = q;
    d.cam_s1 = {CAM_PHASE_INPUT_TWO, CAM_PHASE_INPUT_ONE};
    d.cam_s2 = q.cam_s1;
    d.cam_prev = q.cam_s2;
    cam_rise = q.cam_s2 & ~q.cam_prev;
    for (int k = 0; k < 2; k++)
      if (cam_rise[k])
        d.cam_cap[k] = CRANK_ANGLE;
    if (CRANK_VALID)
      d.prev_ang = CRANK_ANGLE;
    new_cycle = CRANK_VALID && (CRANK_ANGLE < q.prev_ang);
    for (int c = 0; c < `PSCH_CH; c++)
      fire_en[c] = q.pen && (!(q.skip_en[c] && q.mode) || q.skip_act >= q.skip_len ||
                             q.skip_cnt[c] < q.skip_act);

    // Write channels may arrive in either order
    if (S_AXI_AWVALID && q.awready)
    begin
      d.aw_got = 1'b1;
      d.awaddr = S_AXI_AWADDR;
      d.awready = 1'b0;
    end
    if (S_AXI_WVALID && q.wready)
    begin
      d.w_got = 1'b1;
      d.wdata = S_AXI_WDATA;
      d.wstrb = S_AXI_WSTRB;
      d.wready = 1'b0;
    end
    if (q.bvalid && S_AXI_BREADY)
    begin
      d.bvalid = 1'b0;
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      g = q.awaddr[7:4];
      r = q.awaddr[3:2];
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `PSCH_OKAY;
      unique case (g)
        `PSCH_G_CTRL:
          unique case (r)
            `PSCH_R_CTRL:
            begin
              m = merge({24'h0, q.skip_en, 2'h0, q.pen, q.mode}, q.wdata, q.wstrb);
              d.mode = m[`PSCH_MODE_BIT];
              d.pen = m[`PSCH_PEN_BIT];
              d.skip_en = m[`PSCH_SKIP_LSB +: 4];
            end
            `PSCH_R_TRIG:
              trig = q.wstrb[0] ? q.wdata[3:0] : 4'h0;
            `PSCH_R_LEN:
              if (q.wstrb[0])
                d.skip_len = (q.wdata[7:0] == 8'h00) ? `PSCH_SKIP_RST : q.wdata[7:0];
            `PSCH_R_ACT:
              if (q.wstrb[0])
                d.skip_act = (q.wdata[7:0] == 8'h00) ? `PSCH_SKIP_RST : q.wdata[7:0];
          endcase
        `PSCH_G_DELAY:
        begin
          m = merge({16'h0, q.delay[r]}, q.wdata, q.wstrb);
          d.delay[r] = m[15:0];
        end
        `PSCH_G_DUR:
        begin
          m = merge({16'h0, q.dur[r]}, q.wdata, q.wstrb);
          d.dur[r] = m[15:0];
        end
        `PSCH_G_SOI:
        begin
          m = merge({22'h0, q.injection_start_point[r]}, q.wdata, q.wstrb);
          d.injection_start_point[r] = m[9:0];
        end
        `PSCH_G_TDC:
        begin
          m = merge({22'h0, q.tdc[r]}, q.wdata, q.wstrb);
          d.tdc[r] = m[9:0];
        end
        `PSCH_G_CAD, `PSCH_G_STAT:
          d.bresp = (g == `PSCH_G_CAD) ? `PSCH_OKAY : `PSCH_SLVERR;
        default:
          d.bresp = `PSCH_SLVERR;
      endcase
    end

    if (q.rvalid && S_AXI_RREADY)
    begin
      d.rvalid = 1'b0;
      d.arready = 1'b1;
    end
    if (S_AXI_ARVALID && q.arready)
    begin
      g = S_AXI_ARADDR[7:4];
      r = S_AXI_ARADDR[3:2];
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = `PSCH_OKAY;
      d.rdata = '0;
      unique case (g)
        `PSCH_G_CTRL:
          unique case (r)
            `PSCH_R_CTRL:
              d.rdata = {24'h0, q.skip_en, 2'h0, q.pen, q.mode};
            `PSCH_R_TRIG:
              d.rdata = {24'h0, q.pend, busy};
            `PSCH_R_LEN:
              d.rdata = {24'h0, q.skip_len};
            `PSCH_R_ACT:
              d.rdata = {24'h0, q.skip_act};
          endcase
        `PSCH_G_DELAY:
          d.rdata = {16'h0, q.delay[r]};
        `PSCH_G_DUR:
          d.rdata = {16'h0, q.dur[r]};
        `PSCH_G_SOI:
          d.rdata = {22'h0, q.injection_start_point[r]};
        `PSCH_G_TDC:
          d.rdata = {22'h0, q.tdc[r]};
        `PSCH_G_CAD:
          d.rdata = {16'h0, cad(q.dur[r], ENGINE_SPEED)};
        `PSCH_G_STAT:
          if (r == `PSCH_R_STAT)
            d.rdata = {24'h0, q.skip_en & fire_en, q.cmd};
          else if (r == `PSCH_R_CAM_PHASE_INPUT_TWO)
            d.rdata = {22'h0, q.cam_cap[1]};
          else if (r == `PSCH_R_CAM_PHASE_INPUT_ONE)
            d.rdata = {22'h0, q.cam_cap[0]};
          else
            d.rresp = `PSCH_SLVERR;
        default:
          d.rresp = `PSCH_SLVERR;
      endcase
    end

    for (int c = 0; c < `PSCH_CH; c++)
    begin
      crank_fire[c] = q.mode && CRANK_VALID &&
                      crossed(q.prev_ang, CRANK_ANGLE, fire_ang(q.tdc[c], q.injection_start_point[c]));
      d.skip_en_prev[c] = q.skip_en[c] && q.mode;
      // restart on enable, step per cycle
      if (!d.skip_en_prev[c])
        d.skip_cnt[c] = '0;
      else if (!q.skip_en_prev[c])
        d.skip_cnt[c] = '0;
      else if (new_cycle)
        d.skip_cnt[c] = (q.skip_cnt[c] + 8'h01 >= q.skip_len) ? 8'h00
                        : q.skip_cnt[c] + 8'h01;
      launch[c] = !q.mode && (trig[c] || q.pend[c]) && !busy[c];
      d.pend[c] = !q.mode && ((q.pend[c] && !launch[c]) || (trig[c] && !(launch[c] &&
                  !q.pend[c])));
      start_p[c] = launch[c] || (crank_fire[c] && !busy[c]);
    end
    d.cmd = tcmd;
  end

  always_ff @(posedge CORE_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      q <= '0;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
      q.skip_len <= `PSCH_SKIP_RST;
      q.skip_act <= `PSCH_SKIP_RST;
    end
    else
      q <= d;
  end

  assign S_AXI_AWREADY = q.awready;
  assign S_AXI_WREADY = q.wready;
  assign S_AXI_BVALID = q.bvalid;
  assign S_AXI_BRESP = q.bresp;
  assign S_AXI_ARREADY = q.arready;
  assign S_AXI_RVALID = q.rvalid;
  assign S_AXI_RRESP = q.rresp;
  assign S_AXI_RDATA = q.rdata;
  assign INJ_CMD = q.cmd;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!ARST_N);

  rd_latency_a:
  assert property ((S_AXI_ARVALID && S_AXI_ARREADY) |=> S_AXI_RVALID && !S_AXI_ARREADY)
  else $error("Read answer not one cycle after address");

  wr_answer_a:
  assert property ((S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY)
    |=> ##1 S_AXI_BVALID)
  else $error("Write answer missing two cycles after both channels");

  cam_capture_a:
  assert property (cam_rise[1] |=> q.cam_cap[1] == $past(CRANK_ANGLE))
  else $error("Cam two edge did not capture angle");

  len_floor_a:
  assert property (q.skip_len != 8'h00 && q.skip_act != 8'h00)
  else $error("Skip length or count fell to zero");

  skip_suppress_a:
  assert property ((q.mode && q.skip_en[0] && q.skip_act < q.skip_len &&
    q.skip_cnt[0] >= q.skip_act) |-> !fire_en[0])
  else $error("Skipped cycle was not suppressed");

  skip_restart_a:
  assert property ($rose(q.skip_en[0] && q.mode) |=> q.skip_cnt[0] == 8'h00 ##1
    (q.skip_cnt[0] <= 8'h01))
  else $error("Skip counter did not restart");

  skip_full_a:
  assert property ((q.pen && q.skip_act >= q.skip_len) |-> fire_en[1])
  else $error("Saturated count left a cycle inactive");

  mode_gate_a:
  assert property (!q.mode |-> crank_fire == 4'h0)
  else $error("Angle scheduling ran in time-based mode");

  manual_once_a:
  assert property ((launch[3] && !q.pend[3]) |=> !launch[3])
  else $error("Manual trigger launched twice");
endmodule : psch_top
`default_nettype wire

// File: verif/psch_crank_model.sv
// Crank angle and cam phase source standing in for the position tracker
`timescale 1ns/1ps
`default_nettype none
module psch_crank_model
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  output logic [9:0] angle,
  output logic valid,
  output logic cam_one,
  output logic cam_two
);
  logic [2:0] sub;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      angle <= 10'h3ff;
      valid <= 1'b0;
      sub <= 3'h0;
    end
    else if (!run)
    begin
      // Stopped engine: angle shown inverted, restored on restart
      valid <= 1'b0;
      if (valid)
        angle <= ~angle;
    end
    else if (!valid)
    begin
      valid <= 1'b1;
      angle <= ~angle;
      sub <= 3'h0;
    end
    else
    begin
      sub <= sub + 3'h1;
      if (sub == 3'h7)
        angle <= (angle == 10'h2cf) ? 10'h000 : angle + 10'h001;
    end
  end
  assign cam_one = valid && angle >= 10'h0c8 && angle < 10'h168;
  assign cam_two = valid && angle >= 10'h190 && angle < 10'h230;
endmodule : psch_crank_model
`default_nettype wire

// File: verif/test_port_injection_pulse_scheduler.sv
// Self-checking bench for the port injection pulse scheduler
`timescale 1ns/1ps
`default_nettype none
`include "psch_consts.svh"
module test_port_injection_pulse_scheduler;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bready = 1'b0;
  logic arv = 1'b0;
  logic rready = 1'b0;
  logic run = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, cvalid, cam_phase_input_one, cam_phase_input_two;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [1:0] rd_resp = 2'h0;
  logic [3:0] inj;
  logic [9:0] ang;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int rises [4] = '{default: 0};
  int len [4] = '{default: 0};
  int cur [4] = '{default: 0};
  int rise_at [4] = '{default: 0};
  localparam int ECYC = 5760;
  always #5 clk = ~clk;
  psch_top psch_top_inst (.CORE_CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CRANK_ANGLE(ang), .CRANK_VALID(cvalid), .ENGINE_SPEED(16'h0180),
    .CAM_PHASE_INPUT_ONE(cam_phase_input_one), .CAM_PHASE_INPUT_TWO(cam_phase_input_two), .INJ_CMD(inj));
  psch_crank_model psch_crank_model_inst (.clk(clk), .arst_n(arst_n), .run(run),
    .angle(ang), .valid(cvalid), .cam_one(cam_phase_input_one), .cam_two(cam_phase_input_two));
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Ready is sampled mid-cycle, so the edge that follows is the handshake edge
  task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ra, rw, rb, pa, pw, pb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    pb = 1'b1;
    while (pb)
    begin
      @(negedge clk);
      ra = awready;
      rw = wready;
      rb = bvalid;
      r = bresp;
      @(posedge clk);
      pa = pa & ~ra;
      awv <= pa;
      pw = pw & ~rw;
      wv <= pw;
      pb = pb & ~rb;
      bready <= pb;
    end
  endtask : axw
  task axr(input logic [7:0] a, output logic [31:0] d);
    logic ra, rv, pa, pr;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    pa = 1'b1;
    pr = 1'b1;
    while (pr)
    begin
      @(negedge clk);
      ra = arready;
      rv = rvalid;
      d = rdata;
      rd_resp = rresp;
      @(posedge clk);
      pa = pa & ~ra;
      arv <= pa;
      pr = pr & ~rv;
      rready <= pr;
    end
  endtask : axr
  // Pulse counting and timeout run off the falling edge, clear of updates
  always @(negedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      fail_count++;
      tally_and_finish();
    end
    for (int c = 0; c < 4; c++)
    begin
      if (inj[c] === 1'b1)
      begin
        if (cur[c] == 0)
          rise_at[c] = cyc;
        if (cur[c] == 0)
          rises[c]++;
        cur[c]++;
      end
      else if (cur[c] != 0)
      begin
        len[c] = cur[c];
        cur[c] = 0;
      end
    end
  end
  initial
  begin
    logic [31:0] v;
    logic [1:0] rsp;
    int t0, b0, b1;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    axr(8'h00, v);
    chk(v, 32'h0);
    axr(8'h08, v);
    chk(v, 32'h1);
    axw(8'h08, 32'h0, rsp);
    axr(8'h08, v);
    chk(v, 32'h1);
    axw(8'h0c, 32'h0, rsp);
    axr(8'h0c, v);
    chk(v, 32'h1);
    axw(8'hfc, 32'h5, rsp);
    chk({30'h0, rsp}, {30'h0, `PSCH_SLVERR});
    axr(8'hfc, v);
    chk({30'h0, rd_resp}, {30'h0, `PSCH_SLVERR});
    axw(8'h50, 32'h7, rsp);
    axr(8'h50, v);
    chk(v, 32'h0);
    axw(8'h44, 32'h155, rsp);
    axr(8'h44, v);
    chk(v, 32'h155);
    chk({30'h0, rd_resp}, {30'h0, `PSCH_OKAY});
    axr(8'h40, v);
    chk(v, 32'h0);
    $display("test registers done");
    for (int c = 0; c < 4; c++)
    begin
      axw(8'(32'h10 + 4 * c), 32'h1, rsp);
      axw(8'(32'h20 + 4 * c), 32'(c + 1), rsp);
    end
    // Skip enable on channel 0 must not bite in time-based mode
    axw(8'h00, 32'h12, rsp);
    axw(8'h04, 32'hf, rsp);
    t0 = cyc;
    repeat (6000) @(posedge clk);
    for (int c = 0; c < 4; c++)
    begin
      chk(32'(rises[c]), 32'h1);
      chk(32'(len[c] > c * `PSCH_TICK_CYC && len[c] <= (c + 1) * `PSCH_TICK_CYC), 32'h1);
    end
    chk(32'(rise_at[0] - t0 > 0 && rise_at[0] - t0 <= 2 * `PSCH_TICK_CYC + 5), 32'h1);
    $display("test time mode done");
    axw(8'h00, 32'h0, rsp);
    axw(8'h04, 32'h1, rsp);
    axr(8'h04, v);
    chk({28'h0, v[3:0]}, 32'h1);
    repeat (4000) @(posedge clk);
    chk(32'(rises[0]), 32'h1);
    axr(8'h04, v);
    chk({28'h0, v[3:0]}, 32'h0);
    $display("test masked pulse done");
    for (int c = 0; c < 4; c++)
      axw(8'(32'h40 + 4 * c), 32'h100, rsp);
    axr(8'h54, v);
    chk(v, 32'h3);
    axw(8'h08, 32'h3, rsp);
    axw(8'h0c, 32'h2, rsp);
    axw(8'h00, 32'h13, rsp);
    b0 = rises[0];
    b1 = rises[1];
    run <= 1'b1;
    repeat (6 * ECYC + 100) @(posedge clk);
    run <= 1'b0;
    chk(32'(rises[0] - b0), 32'h4);
    chk(32'(rises[1] - b1), 32'h6);
    axr(8'h60, v);
    chk(v, 32'hc8);
    axr(8'h64, v);
    chk(v, 32'h190);
    axw(8'h0c, 32'h3, rsp);
    b0 = rises[0];
    run <= 1'b1;
    repeat (3 * ECYC + 100) @(posedge clk);
    run <= 1'b0;
    chk(32'(rises[0] - b0), 32'h3);
    $display("test crank mode done");
    tally_and_finish();
  end
endmodule : test_port_injection_pulse_scheduler
`default_nettype wire
